// ---- verilog/key_wake_unit.sv ----
// Key wake unit: APB registers, shared key flag, port pin control and wake logic.
//
// Summary of operation
// - One unit, eight inputs sharing 8-bit port.
// - Eight pin enables, any combination allowed.
// - Enabled pins forced input; others plain port.
// - Selectable edge-only or edge-and-level detection.
// - Inputs 3-0 active low; 7-4 selectable.
// - Eight pull enables, active on input pins.
// - High-polarity key inputs 7-4 get pulldown.
// - Key event wakes from wait and standby.
// - One shared flag and one interrupt enable.
// - Edges seen across two consecutive bus cycles.
// - Flag with enable requests interrupt; else polling.
// - Edge mode: acknowledge clears flag, reads zero.
// - Level mode: flag held while input asserted.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module key_wake_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [key_wake_pkg::PORT_W-1:0] port_in,
  output logic [key_wake_pkg::PORT_W-1:0] port_out,
  output logic [key_wake_pkg::PORT_W-1:0] port_oe,
  output logic [key_wake_pkg::PORT_W-1:0] pull_up_en,
  output logic [key_wake_pkg::PORT_W-1:0] pull_down_en,
  input wire logic wait_mode,
  input wire logic low_power_stop_standby,
  output logic cpu_wake,
  output logic key_irq,
  output logic irq
);

  // Software-visible state.
  key_wake_pkg::key_ctrl_s ctrl;
  logic key_event_flag;
  logic [key_wake_pkg::PORT_W-1:0] key_pin_enable_set;
  logic [key_wake_pkg::PORT_W-1:0] port_a_data_reg;
  logic [key_wake_pkg::PORT_W-1:0] port_a_direction_reg;
  logic [key_wake_pkg::PORT_W-1:0] port_a_pull_enable_reg;
  logic [key_wake_pkg::IRQ_W-1:0] irq_status;
  logic [key_wake_pkg::IRQ_W-1:0] irq_mask;

  // Internal signals.
  logic access;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [31:0] next_prdata;
  logic [key_wake_pkg::PORT_W-1:0] asserted;
  logic [key_wake_pkg::PORT_W-1:0] edge_hit;
  logic [key_wake_pkg::PORT_W-1:0] drive_dir;
  logic any_edge;
  logic any_asserted;
  logic key_event_acknowledge;
  logic next_key_event_flag;
  logic [key_wake_pkg::IRQ_W-1:0] next_irq_status;
  logic stop_wake;
  logic wake_prev;
  logic wake_event;

  // Detection of edges and asserted levels on the enabled pins.
  key_sense u_sense (
    .pclk(pclk),
    .presetn(presetn),
    .pins(port_in),
    .key_pin_enable_set(key_pin_enable_set),
    .key_polarity_select(ctrl.key_polarity_select),
    .asserted(asserted),
    .edge_hit(edge_hit)
  );

  // All eight inputs fold into one event and one level term.
  assign any_edge = |edge_hit;
  assign any_asserted = |asserted;

  // APB handshake: one wait state so that pready and prdata come from flip-flops.
  assign access = psel & penable;
  assign wr_done = access & pready & pwrite;
  assign rd_done = access & pready & ~pwrite;
  assign mapped = (paddr == key_wake_pkg::OFS_CTRL) | (paddr == key_wake_pkg::OFS_PIN_EN) |
    (paddr == key_wake_pkg::OFS_PORT_DATA) | (paddr == key_wake_pkg::OFS_PORT_DIR) |
    (paddr == key_wake_pkg::OFS_PORT_PULL) | (paddr == key_wake_pkg::OFS_IRQ_STATUS) |
    (paddr == key_wake_pkg::OFS_IRQ_MASK);

  // Read data mux; the acknowledge bit always reads as zero.
  always_comb begin
    next_prdata = key_wake_pkg::RST_WORD;
    unique case (paddr)
      key_wake_pkg::OFS_CTRL: begin
        next_prdata[key_wake_pkg::CTRL_MODE_BIT] = ctrl.key_detect_mode;
        next_prdata[key_wake_pkg::CTRL_IRQ_EN_BIT] = ctrl.key_irq_enable;
        next_prdata[key_wake_pkg::CTRL_ACK_BIT] = 1'b0;
        next_prdata[key_wake_pkg::CTRL_FLAG_BIT] = key_event_flag;
        next_prdata[key_wake_pkg::CTRL_POL_LSB +: key_wake_pkg::POL_W] = ctrl.key_polarity_select;
      end
      key_wake_pkg::OFS_PIN_EN: begin
        next_prdata[key_wake_pkg::PORT_W-1:0] = key_pin_enable_set;
      end
      key_wake_pkg::OFS_PORT_DATA: begin
        // Output pins read back the latch, input pins read the pin level.
        next_prdata[key_wake_pkg::PORT_W-1:0] = (drive_dir & port_a_data_reg) | (~drive_dir & port_in);
      end
      key_wake_pkg::OFS_PORT_DIR: begin
        next_prdata[key_wake_pkg::PORT_W-1:0] = port_a_direction_reg;
      end
      key_wake_pkg::OFS_PORT_PULL: begin
        next_prdata[key_wake_pkg::PORT_W-1:0] = port_a_pull_enable_reg;
      end
      key_wake_pkg::OFS_IRQ_STATUS: begin
        next_prdata[key_wake_pkg::IRQ_W-1:0] = irq_status;
      end
      key_wake_pkg::OFS_IRQ_MASK: begin
        next_prdata[key_wake_pkg::IRQ_W-1:0] = irq_mask;
      end
      default: begin
        next_prdata = key_wake_pkg::RST_WORD;
      end
    endcase
  end

  // Bus answer registers; an unmapped address completes with pslverr.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= key_wake_pkg::RST_WORD;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access & ~pready & ~pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Control register; the flag and acknowledge bits are not stored here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.key_polarity_select <= key_wake_pkg::RST_POL;
      ctrl.key_irq_enable <= 1'b0;
      ctrl.key_detect_mode <= key_wake_pkg::DETECT_EDGE_ONLY;
    end else if (wr_done && paddr == key_wake_pkg::OFS_CTRL) begin
      ctrl.key_polarity_select <= pwdata[key_wake_pkg::CTRL_POL_LSB +: key_wake_pkg::POL_W];
      ctrl.key_irq_enable <= pwdata[key_wake_pkg::CTRL_IRQ_EN_BIT];
      ctrl.key_detect_mode <= key_wake_pkg::detect_mode_e'(pwdata[key_wake_pkg::CTRL_MODE_BIT]);
    end
  end

  // Pin enables and the port registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_pin_enable_set <= key_wake_pkg::RST_BYTE;
      port_a_data_reg <= key_wake_pkg::RST_BYTE;
      port_a_direction_reg <= key_wake_pkg::RST_BYTE;
      port_a_pull_enable_reg <= key_wake_pkg::RST_BYTE;
    end else if (wr_done) begin
      if (paddr == key_wake_pkg::OFS_PIN_EN) begin
        key_pin_enable_set <= pwdata[key_wake_pkg::PORT_W-1:0];
      end
      if (paddr == key_wake_pkg::OFS_PORT_DATA) begin
        port_a_data_reg <= pwdata[key_wake_pkg::PORT_W-1:0];
      end
      if (paddr == key_wake_pkg::OFS_PORT_DIR) begin
        port_a_direction_reg <= pwdata[key_wake_pkg::PORT_W-1:0];
      end
      if (paddr == key_wake_pkg::OFS_PORT_PULL) begin
        port_a_pull_enable_reg <= pwdata[key_wake_pkg::PORT_W-1:0];
      end
    end
  end

  // A key pin never drives, whatever the direction register says.
  assign drive_dir = port_a_direction_reg & ~key_pin_enable_set;

  // Pin drive and pull controls, registered so the pads see clean levels.
  // Pulls only apply to pins acting as inputs; high-polarity key pins 7..4
  // swap to a pulldown so an idle key reads deasserted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= key_wake_pkg::RST_BYTE;
      port_oe <= key_wake_pkg::RST_BYTE;
      pull_up_en <= key_wake_pkg::RST_BYTE;
      pull_down_en <= key_wake_pkg::RST_BYTE;
    end else begin
      port_out <= port_a_data_reg;
      port_oe <= drive_dir;
      for (int i = 0; i < key_wake_pkg::PORT_W; i++) begin
        if (i >= key_wake_pkg::POL_BASE && key_pin_enable_set[i] &&
            ctrl.key_polarity_select[i-key_wake_pkg::POL_BASE]) begin
          pull_up_en[i] <= 1'b0;
          pull_down_en[i] <= port_a_pull_enable_reg[i];
        end else begin
          pull_up_en[i] <= port_a_pull_enable_reg[i] & ~drive_dir[i];
          pull_down_en[i] <= 1'b0;
        end
      end
    end
  end

  // Acknowledge is a write-only strobe on the control register.
  assign key_event_acknowledge = wr_done && paddr == key_wake_pkg::OFS_CTRL &&
    pwdata[key_wake_pkg::CTRL_ACK_BIT];

  // Shared flag: an edge or, in level mode, any held key sets it; a set in the
  // same cycle as an acknowledge wins so no key press is lost.
  always_comb begin
    next_key_event_flag = key_event_flag;
    if (any_edge || (ctrl.key_detect_mode == key_wake_pkg::DETECT_EDGE_LEVEL && any_asserted)) begin
      next_key_event_flag = 1'b1;
    end else if (key_event_acknowledge) begin
      next_key_event_flag = 1'b0;
    end
  end

  // Flag and its interrupt request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_event_flag <= 1'b0;
      key_irq <= 1'b0;
    end else begin
      key_event_flag <= next_key_event_flag;
      // The enable written in this cycle takes effect with the flag, so the pin never lags the control bit.
      key_irq <= next_key_event_flag & ((wr_done && paddr == key_wake_pkg::OFS_CTRL) ?
        pwdata[key_wake_pkg::CTRL_IRQ_EN_BIT] : ctrl.key_irq_enable);
    end
  end

  // In stop the clock is gone, so an asserted key sets the wake flop directly.
  assign stop_wake = low_power_stop_standby & any_asserted;

  // Wake request: in wait an edge, or a held key that newly sets the flag in level mode; asynchronous level in stop.
  // It drops once the system has left both low-power modes.
  always_ff @(posedge pclk or negedge presetn or posedge stop_wake) begin
    if (!presetn) begin
      cpu_wake <= 1'b0;
    end else if (stop_wake) begin
      cpu_wake <= 1'b1;
    end else if (wait_mode && (any_edge || (next_key_event_flag && !key_event_flag))) begin
      cpu_wake <= 1'b1;
    end else if (!wait_mode && !low_power_stop_standby) begin
      cpu_wake <= 1'b0;
    end
  end

  // Rising edge of the wake request, seen once the clock is back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_prev <= 1'b0;
    end else begin
      wake_prev <= cpu_wake;
    end
  end
  assign wake_event = cpu_wake & ~wake_prev;

  // Sticky status: events set bits, a read of the register clears them, and a
  // new event in the reading cycle survives the clear.
  always_comb begin
    next_irq_status = irq_status;
    if (rd_done && paddr == key_wake_pkg::OFS_IRQ_STATUS) begin
      next_irq_status = key_wake_pkg::RST_IRQ;
    end
    if (any_edge) begin
      next_irq_status[key_wake_pkg::IRQ_KEY_BIT] = 1'b1;
    end
    if (wake_event) begin
      next_irq_status[key_wake_pkg::IRQ_WAKE_BIT] = 1'b1;
    end
  end

  // Status, mask and the combined interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= key_wake_pkg::RST_IRQ;
      irq_mask <= key_wake_pkg::RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_done && paddr == key_wake_pkg::OFS_IRQ_MASK) begin
        irq_mask <= pwdata[key_wake_pkg::IRQ_W-1:0];
      end
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // Checks on the design's own outputs and state.
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence

  property p_apb_one_wait;
    @(posedge pclk) disable iff (!presetn)
    s_setup ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait) else $error("APB answer not after one wait state");

  property p_key_dir_forced;
    @(posedge pclk) disable iff (!presetn)
    ##1 ((port_oe & $past(key_pin_enable_set)) == 8'h00);
  endproperty
  a_key_dir_forced: assert property (p_key_dir_forced) else $error("Key pin driven as output");

  property p_edge_sets_flag;
    @(posedge pclk) disable iff (!presetn)
    any_edge |=> key_event_flag ##0 (!ctrl.key_irq_enable || key_irq);
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("Edge did not set flag");

  property p_ack_clears;
    @(posedge pclk) disable iff (!presetn)
    key_event_acknowledge && ctrl.key_detect_mode == key_wake_pkg::DETECT_EDGE_ONLY && !any_edge
      |=> !key_event_flag && !key_irq;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("Acknowledge did not clear flag");

  property p_level_holds;
    @(posedge pclk) disable iff (!presetn)
    ctrl.key_detect_mode == key_wake_pkg::DETECT_EDGE_LEVEL && any_asserted |=> key_event_flag;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("Level mode flag not held");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
    key_irq == (key_event_flag && ctrl.key_irq_enable);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("Key interrupt does not match flag");

  property p_pull_split;
    @(posedge pclk) disable iff (!presetn)
    (pull_up_en & pull_down_en) == 8'h00 && pull_down_en[3:0] == 4'h0;
  endproperty
  a_pull_split: assert property (p_pull_split) else $error("Pull devices overlap");

  property p_wait_wake;
    @(posedge pclk) disable iff (!presetn)
    wait_mode && any_edge |=> cpu_wake;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("No wake from wait");

  property p_reset_clear;
    @(posedge pclk)
    $rose(presetn) |-> !key_event_flag && key_pin_enable_set == 8'h00 && !key_irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("State not clear after reset");

  property p_status_read_clear;
    @(posedge pclk) disable iff (!presetn)
    s_access ##0 (!pwrite && paddr == key_wake_pkg::OFS_IRQ_STATUS && !any_edge && !wake_event)
      |=> irq_status == 2'h0;
  endproperty
  a_status_read_clear: assert property (p_status_read_clear) else $error("Status read did not clear");

endmodule // key_wake_unit

// ---- verilog/key_wake_pkg.sv ----
// Shared constants and carrier types for the key wake unit and its port.
package key_wake_pkg;

  // Port width and the split between fixed and selectable polarity inputs.
  localparam int PORT_W = 8;
  localparam int POL_W = 4;
  localparam int POL_BASE = 4;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PIN_EN = 8'h04;
  localparam logic [7:0] OFS_PORT_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT_DIR = 8'h0C;
  localparam logic [7:0] OFS_PORT_PULL = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // Field positions in the control register.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;
  localparam int CTRL_FLAG_BIT = 3;
  localparam int CTRL_POL_LSB = 4;

  // Field positions in the interrupt status and mask registers.
  localparam int IRQ_W = 2;
  localparam int IRQ_KEY_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_POL = 4'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Detection mode encodings.
  typedef enum logic {
    DETECT_EDGE_ONLY = 1'b0,
    DETECT_EDGE_LEVEL = 1'b1
  } detect_mode_e;

  // Control register settings held together; only the polarity selects feed the detector.
  typedef struct packed {
    logic [POL_W-1:0] key_polarity_select;
    logic key_irq_enable;
    detect_mode_e key_detect_mode;
  } key_ctrl_s;

endpackage

// ---- verilog/key_sense.sv ----
// Per-pin asserted-level and synchronous edge detection for the key inputs.
`timescale 1ns/1ns
module key_sense (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [key_wake_pkg::PORT_W-1:0] pins,
  input wire logic [key_wake_pkg::PORT_W-1:0] key_pin_enable_set,
  input wire logic [key_wake_pkg::POL_W-1:0] key_polarity_select,
  output logic [key_wake_pkg::PORT_W-1:0] asserted,
  output logic [key_wake_pkg::PORT_W-1:0] edge_hit
);

  logic [key_wake_pkg::PORT_W-1:0] prev_pin;

  // Previous bus-cycle sample of every pin, kept even for disabled pins so that
  // enabling a pin that is already asserted does not fake an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_pin <= key_wake_pkg::RST_BYTE;
    end else begin
      prev_pin <= pins;
    end
  end

  // Low pins are fixed active low, high pins take their polarity select.
  for (genvar i = 0; i < key_wake_pkg::PORT_W; i++) begin : g_bit
    logic high_active;
    if (i < key_wake_pkg::POL_BASE) begin : g_fixed
      assign high_active = 1'b0;
    end else begin : g_sel
      assign high_active = key_polarity_select[i-key_wake_pkg::POL_BASE];
    end
    assign asserted[i] = key_pin_enable_set[i] & (high_active ? pins[i] : ~pins[i]);
    // Deasserted in one cycle, asserted in the next.
    assign edge_hit[i] = key_pin_enable_set[i] &
      (high_active ? (~prev_pin[i] & pins[i]) : (prev_pin[i] & ~pins[i]));
  end

endmodule // key_sense

// ---- test/key_pad_model.sv ----
// Keypad model that resolves each port pin from the unit's drivers, the keys and the pulls.
`timescale 1ns/1ns
module key_pad_model (
  input wire logic pclk,
  input wire logic [7:0] port_oe,
  input wire logic [7:0] port_out,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_down_en,
  input wire logic [7:0] key_drive,
  input wire logic [7:0] key_level,
  output logic [7:0] pin_level
);
  // An undriven, unpulled pin flips each cycle, so a settled unknown can never look like a clean level.
  logic wander;
  initial wander = 1'b0;
  always @(posedge pclk) wander <= ~wander;
  // The unit's own driver wins, then a key, then a pull device.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port_oe[i])
        pin_level[i] = port_out[i];
      else if (key_drive[i])
        pin_level[i] = key_level[i];
      else if (pull_up_en[i] || pull_down_en[i])
        pin_level[i] = pull_up_en[i];
      else
        pin_level[i] = wander;
    end
  end
endmodule // key_pad_model

// ---- test/keyboard_wake_interrupt_tb_top.sv ----
// Self-checking bench for the key wake unit with a keypad on its port.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("BAD %s exp=%0h got=%0h", nm, (e), (g)); \
  end \
end
module keyboard_wake_interrupt_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic wait_mode, low_power_stop_standby, cpu_wake, key_irq, irq;
  logic [7:0] paddr, port_in, port_out, port_oe, pull_up_en, pull_down_en, key_drive, key_level;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] m_en, m_dir, m_pull, m_data, pd, drv;
  logic [3:0] m_pol;
  logic m_flag, m_ie, m_mode;
  int fail_count, compares, seed;

  key_wake_unit u_key_wake_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .wait_mode(wait_mode), .low_power_stop_standby(low_power_stop_standby),
    .cpu_wake(cpu_wake), .key_irq(key_irq), .irq(irq));
  key_pad_model u_key_pad_model (.pclk(pclk), .port_oe(port_oe), .port_out(port_out),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .key_drive(key_drive),
    .key_level(key_level), .pin_level(port_in));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // One APB transfer; the request is held until pready is sampled high, with no cycle count assumed.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("BAD apb_ready exp=1 got=0");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask

  // Control word as the model expects it; the acknowledge bit always reads back as zero.
  function automatic logic [31:0] ctrl_exp();
    return {24'h00_0000, m_pol, m_flag, 1'b0, m_ie, m_mode};
  endfunction

  task automatic wr_ctrl(input logic ack);
    apb(1'b1, key_wake_pkg::OFS_CTRL, {24'h00_0000, m_pol, 1'b0, ack, m_ie, m_mode});
  endtask

  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, wait_mode, low_power_stop_standby} = '0;
    {key_drive, key_level, m_en, m_dir, m_pull, m_pol, m_flag, m_ie, m_mode} = '0;
    fail_count = 0;
    compares = 0;
    seed = 70997;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Everything starts cleared, and an unmapped address is refused.
    rdchk("ctrl_rst", key_wake_pkg::OFS_CTRL, 32'h0);
    rdchk("pin_en_rst", key_wake_pkg::OFS_PIN_EN, 32'h0);
    rdchk("mask_rst", key_wake_pkg::OFS_IRQ_MASK, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("oe_rst", 8'h00, port_oe)
    $display("test reset done");

    // Random pin enables, directions, pulls and polarities; keys hold every undriven pin at its idle level.
    for (int k = 0; k < 6; k++) begin
      {m_en, m_dir, m_pull, m_data} = $random(seed);
      m_pol = 4'($random(seed));
      apb(1'b1, key_wake_pkg::OFS_PIN_EN, {24'h0, m_en});
      apb(1'b1, key_wake_pkg::OFS_PORT_DIR, {24'h0, m_dir});
      apb(1'b1, key_wake_pkg::OFS_PORT_PULL, {24'h0, m_pull});
      apb(1'b1, key_wake_pkg::OFS_PORT_DATA, {24'h0, m_data});
      wr_ctrl(1'b0);
      drv = m_dir & ~m_en;
      key_drive <= ~drv;
      key_level <= {~m_pol, 4'hF};
      repeat (3) @(posedge pclk);
      pd = m_pull & m_en & {m_pol, 4'h0};
      `CHK("port_oe", drv, port_oe)
      `CHK("port_out", m_data, port_out)
      `CHK("pull_down", pd, pull_down_en)
      `CHK("pull_up", m_pull & ~drv & ~pd, pull_up_en)
      rdchk("port_data", key_wake_pkg::OFS_PORT_DATA, {24'h0, (m_data & drv) | ({~m_pol, 4'hF} & ~drv)});
    end
    $display("test port done");

    // Every pin raises the one shared flag on its asserted edge; pins 7..4 mix both polarities.
    m_pol = 4'hA;
    m_en = 8'hFF;
    m_ie = 1'b1;
    apb(1'b1, key_wake_pkg::OFS_PIN_EN, 32'h0000_00FF);
    apb(1'b1, key_wake_pkg::OFS_PORT_DIR, 32'h0);
    apb(1'b1, key_wake_pkg::OFS_IRQ_MASK, 32'h1);
    key_drive <= 8'hFF;
    key_level <= {~m_pol, 4'hF};
    wr_ctrl(1'b0);
    repeat (3) @(posedge pclk);
    wr_ctrl(1'b1);
    apb(1'b0, key_wake_pkg::OFS_IRQ_STATUS, 32'h0);
    rdchk("ctrl_clear", key_wake_pkg::OFS_CTRL, ctrl_exp());
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      key_level[i] <= ~key_level[i];
      repeat (3) @(posedge pclk);
      m_flag = 1'b1;
      `CHK("key_irq", 1'b1, key_irq)
      `CHK("irq", 1'b1, irq)
      rdchk("ctrl_flag", key_wake_pkg::OFS_CTRL, ctrl_exp());
      key_level[i] <= ~key_level[i];
      wr_ctrl(1'b1);
      m_flag = 1'b0;
      rdchk("ctrl_ack", key_wake_pkg::OFS_CTRL, ctrl_exp());
      rdchk("status", key_wake_pkg::OFS_IRQ_STATUS, 32'h1);
      @(posedge pclk);
      `CHK("irq_clear", 1'b0, irq)
    end
    $display("test edges done");

    // Polling only, then a held level: edge mode clears on acknowledge, level mode cannot.
    m_ie = 1'b0;
    wr_ctrl(1'b0);
    apb(1'b1, key_wake_pkg::OFS_IRQ_MASK, 32'h0);
    key_level[0] <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("key_irq_off", 1'b0, key_irq)
    `CHK("irq_masked", 1'b0, irq)
    wr_ctrl(1'b1);
    rdchk("edge_held_ack", key_wake_pkg::OFS_CTRL, ctrl_exp());
    m_mode = 1'b1;
    m_flag = 1'b1;
    wr_ctrl(1'b1);
    repeat (2) @(posedge pclk);
    rdchk("level_held", key_wake_pkg::OFS_CTRL, ctrl_exp());
    key_level[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    wr_ctrl(1'b1);
    m_flag = 1'b0;
    rdchk("level_gone", key_wake_pkg::OFS_CTRL, ctrl_exp());
    apb(1'b0, key_wake_pkg::OFS_IRQ_STATUS, 32'h0);
    $display("test modes done");

    // Wake from wait by an edge, then from standby by a level with no clock edge in between.
    wait_mode <= 1'b1;
    key_level[1] <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("wake_wait", 1'b1, cpu_wake)
    wait_mode <= 1'b0;
    key_level[1] <= 1'b1;
    wr_ctrl(1'b1);
    repeat (3) @(posedge pclk);
    `CHK("wake_off", 1'b0, cpu_wake)
    low_power_stop_standby <= 1'b1;
    @(posedge pclk);
    key_level[2] <= 1'b0;
    #2;
    `CHK("wake_stop", 1'b1, cpu_wake)
    @(posedge pclk);
    low_power_stop_standby <= 1'b0;
    key_level[2] <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, key_wake_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK("wake_status", 1'b1, rd[key_wake_pkg::IRQ_WAKE_BIT])
    $display("test wake done");
    end_sim();
  end
endmodule // keyboard_wake_interrupt_tb_top
